// ===== core/smsp_pkg.sv
// Package of the serial master/slave port: constants, state types, helpers.
// Assumes a single 50 MHz system clock; all pin inputs already synchronous.
package smsp_pkg;

    // ------------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------------
    localparam int         BYTE_W             = 8;
    localparam logic [4:0] EDGES_PER_BYTE     = 5'h10;
    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
    localparam int         CLK_PERIOD_NS      = 20;
    localparam int         SCK_MIN_PHASE_CLKS = 2;
    localparam logic [1:0] BUF_DEPTH          = 2'h2;

    // Half periods of the master clock for the four rate codes
    localparam logic [6:0] HALF_DIV4   = 7'h02;
    localparam logic [6:0] HALF_DIV16  = 7'h08;
    localparam logic [6:0] HALF_DIV64  = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} smsp_state_t;

    typedef struct packed {
        smsp_state_t       state;
        logic [6:0]        div_cnt;
        logic              sck_lvl;
        logic [4:0]        edge_cnt;
        logic [3:0]        bit_cnt;
        logic [BYTE_W-1:0] shift;
        logic              out_bit;
        logic              sck_prev;
        logic              done_flag;
        logic              irq;
        logic              fault;
        logic              push;
        logic [BYTE_W-1:0] push_data;
    } smsp_core_t;

    typedef struct packed {
        logic [1:0][BYTE_W-1:0] mem;
        logic                   wp;
        logic                   rp;
        logic [1:0]             cnt;
    } smsp_buf_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] half_period(input logic [1:0] rate,
                                               input logic       dbl);
        logic [6:0] base;
        case (rate)
            2'h0:    base = HALF_DIV4;
            2'h1:    base = HALF_DIV16;
            2'h2:    base = HALF_DIV64;
            default: base = HALF_DIV128;
        endcase
        half_period = dbl ? (base >> 1) : base;
    endfunction : half_period

    function automatic logic out_end(input logic [BYTE_W-1:0] sr,
                                     input logic              lsb);
        out_end = lsb ? sr[0] : sr[BYTE_W-1];
    endfunction : out_end

    function automatic logic [BYTE_W-1:0] shift_in(
        input logic [BYTE_W-1:0] sr,
        input logic              b,
        input logic              lsb);
        shift_in = lsb ? {b, sr[BYTE_W-1:1]} : {sr[BYTE_W-2:0], b};
    endfunction : shift_in

endpackage : smsp_pkg

// ===== core/smsp_buf_if.sv
// Carrier between the port core and its receive buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface smsp_buf_if;
    import smsp_pkg::*;
    logic              in_valid;
    logic              in_ready;
    logic [BYTE_W-1:0] in_data;
    logic              out_valid;
    logic              out_ready;
    logic [BYTE_W-1:0] out_data;

    modport buffer (input  in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
    modport user   (output in_valid, in_data, out_ready,
                    input  in_ready, out_valid, out_data);
endinterface : smsp_buf_if

// ===== core/smsp_rx_buf.sv
// Two-entry receive buffer with valid/ready on both sides.
// Assumes reset already synchronised by the instantiating module.
`timescale 1ns/1ns
module smsp_rx_buf
    import smsp_pkg::*;
(
    input  wire logic   clock_in,
    input  wire logic   rstn_in,
    smsp_buf_if.buffer  bus
);
    smsp_buf_t buf_reg;
    smsp_buf_t buf_next;
    logic      pop;
    logic      push;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // A push into a full buffer is taken only together with a pop
    always_comb begin
        buf_next = buf_reg;
        pop      = (buf_reg.cnt != 2'h0) && bus.out_ready;
        push     = bus.in_valid && ((buf_reg.cnt != BUF_DEPTH) || pop);
        if (push) begin
            buf_next.mem[buf_reg.wp] = bus.in_data;
            buf_next.wp              = ~buf_reg.wp;
        end
        if (pop) begin
            buf_next.rp = ~buf_reg.rp;
        end
        buf_next.cnt = buf_reg.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_reg <= '0;
        end else begin
            buf_reg <= buf_next;
        end
    end

    assign bus.in_ready  = (buf_reg.cnt != BUF_DEPTH);
    assign bus.out_valid = (buf_reg.cnt != 2'h0);
    assign bus.out_data  = buf_reg.mem[buf_reg.rp];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    byte_held_a: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        bus.out_valid && !bus.out_ready
        |=> bus.out_valid && $stable(bus.out_data))
        else $error("unread byte changed");
    oldest_lost_a: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        buf_reg.cnt == BUF_DEPTH && bus.in_valid && bus.out_ready
        |=> buf_reg.cnt == BUF_DEPTH)
        else $error("overrun did not replace oldest byte");
    cover_full_c: cover property (@(posedge clock_in) disable iff (!rstn_in)
        buf_reg.cnt == BUF_DEPTH);

endmodule : smsp_rx_buf

// ===== core/smsp_core.sv
// Byte-wide serial master/slave port with receive buffer.
// Assumes pin inputs are synchronous to clock_in; pad logic outside
// resolves each pin from its out and output-enable pair.
`timescale 1ns/1ns
module smsp_core
    import smsp_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    input  wire logic              power_gate_in,
    input  wire logic              enable_in,
    input  wire logic              irq_enable_in,
    input  wire logic              bit_order_in,
    input  wire logic              master_select_in,
    input  wire logic              polarity_in,
    input  wire logic              phase_in,
    input  wire logic [1:0]        rate_in,
    input  wire logic              double_speed_in,
    input  wire logic              mosi_dir_in,
    input  wire logic              miso_dir_in,
    input  wire logic              sck_dir_in,
    input  wire logic              ss_dir_in,
    input  wire logic              ss_level_in,
    input  wire logic              flag_clear_in,
    input  wire logic              wr_valid_in,
    input  wire logic [BYTE_W-1:0] wr_data_in,
    output logic                   wr_ready_out,
    output logic                   rd_valid_out,
    output logic [BYTE_W-1:0]      rd_data_out,
    input  wire logic              rd_ready_in,
    output logic                   transfer_done_flag_out,
    output logic                   irq_out,
    output logic                   master_active_out,
    output logic                   busy_out,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe_out,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe_out,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe_out,
    input  wire logic              ss_in,
    output logic                   ss_out,
    output logic                   ss_oe_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rstn_sync;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rstn_sync = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------
    smsp_buf_if bus ();

    smsp_rx_buf u_rx_buf (
        .clock_in (clock_in),
        .rstn_in  (rstn_sync),
        .bus      (bus)
    );

    smsp_core_t r_reg;
    smsp_core_t r_next;
    logic       port_on;
    logic       master;
    logic       fault_ev;
    logic       wr_take;
    logic       rx_bit;
    logic       done;
    logic       tick;
    logic       leading;
    logic       sample;
    logic       slave_edge;

    // Master mode drops back to slave on a select fault until software
    // takes the master bit away and sets it again.
    assign port_on  = enable_in && !power_gate_in;
    assign master   = port_on && master_select_in && !r_reg.fault;
    assign fault_ev = master && !ss_dir_in && !ss_in;
    assign rx_bit   = master ? miso_in : mosi_in;

    // Master waits for room in the buffer so its byte is never dropped
    always_comb begin
        if (!port_on) begin
            wr_ready_out = 1'b0;
        end else if (master) begin
            wr_ready_out = (r_reg.state == ST_IDLE) && !fault_ev &&
                           bus.in_ready && !r_reg.push;
        end else begin
            wr_ready_out = ss_in || (r_reg.bit_cnt == 4'h0);
        end
    end
    assign wr_take = wr_valid_in && wr_ready_out;

    // Pulse from the master clock divider
    assign tick = (r_reg.state == ST_SHIFT) &&
        (r_reg.div_cnt == half_period(rate_in, double_speed_in) - 7'h01);

    // Leading edge leaves the idle level; phase picks the sampling edge
    assign slave_edge = (sck_in != r_reg.sck_prev);
    assign leading    = master ? !r_reg.sck_lvl : (sck_in != polarity_in);
    assign sample     = (leading == !phase_in);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_next          = r_reg;
        done            = 1'b0;
        r_next.push     = 1'b0;
        r_next.sck_prev = sck_in;
        if (!master_select_in) begin
            r_next.fault = 1'b0;
        end
        if (fault_ev) begin
            r_next.fault    = 1'b1;
            r_next.state    = ST_IDLE;
            r_next.edge_cnt = 5'h00;
            r_next.bit_cnt  = 4'h0;
            r_next.sck_lvl  = 1'b0;
            done            = 1'b1;
        end else if (master) begin
            r_next.bit_cnt = 4'h0;
            case (r_reg.state)
                ST_IDLE: begin
                    r_next.sck_lvl = 1'b0;
                    if (wr_take) begin
                        r_next.shift    = wr_data_in;
                        r_next.out_bit  = out_end(wr_data_in, bit_order_in);
                        r_next.state    = ST_SHIFT;
                        r_next.div_cnt  = 7'h00;
                        r_next.edge_cnt = 5'h00;
                    end
                end
                ST_SHIFT: begin
                    r_next.div_cnt = r_reg.div_cnt + 7'h01;
                    if (tick) begin
                        r_next.div_cnt  = 7'h00;
                        r_next.sck_lvl  = !r_reg.sck_lvl;
                        r_next.edge_cnt = r_reg.edge_cnt + 5'h01;
                        if (sample) begin
                            r_next.shift = shift_in(r_reg.shift, rx_bit,
                                                    bit_order_in);
                        end else begin
                            r_next.out_bit = out_end(r_reg.shift,
                                                     bit_order_in);
                        end
                        if (r_reg.edge_cnt == EDGES_PER_BYTE - 5'h01) begin
                            r_next.state   = ST_IDLE;
                            r_next.sck_lvl = 1'b0;
                            done           = 1'b1;
                        end
                    end
                end
                default: begin
                    r_next.state = ST_IDLE;
                end
            endcase
        end else if (port_on && !ss_in) begin
            r_next.state = ST_IDLE;
            if (wr_take) begin
                r_next.shift   = wr_data_in;
                r_next.out_bit = out_end(wr_data_in, bit_order_in);
            end else if (slave_edge) begin
                if (sample) begin
                    r_next.shift   = shift_in(r_reg.shift, rx_bit,
                                              bit_order_in);
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    if (r_reg.bit_cnt == BITS_PER_BYTE - 4'h1) begin
                        r_next.bit_cnt = 4'h0;
                        done           = 1'b1;
                    end
                end else begin
                    r_next.out_bit = out_end(r_reg.shift, bit_order_in);
                end
            end
        end else begin
            // Deselected or disabled: partial byte dropped, counters reset
            r_next.state    = ST_IDLE;
            r_next.bit_cnt  = 4'h0;
            r_next.edge_cnt = 5'h00;
            r_next.sck_lvl  = 1'b0;
            if (wr_take) begin
                r_next.shift = wr_data_in;
            end
            r_next.out_bit = out_end(r_next.shift, bit_order_in);
        end
        if (done && !fault_ev) begin
            r_next.push      = 1'b1;
            r_next.push_data = r_next.shift;
        end
        // A completion in the clearing cycle keeps the flag set
        r_next.done_flag = (r_reg.done_flag && !flag_clear_in) || done;
        r_next.irq       = r_next.done_flag && irq_enable_in;
    end

    always_ff @(posedge clock_in or negedge rstn_sync) begin
        if (!rstn_sync) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Buffer hook-up and outputs
    // ------------------------------------------------------------------
    // With the buffer full a slave byte pushes out the oldest one
    assign bus.in_valid  = r_reg.push;
    assign bus.in_data   = r_reg.push_data;
    assign bus.out_ready = rd_ready_in || (r_reg.push && !bus.in_ready);
    assign rd_valid_out  = bus.out_valid;
    assign rd_data_out   = bus.out_data;

    assign transfer_done_flag_out = r_reg.done_flag;
    assign irq_out                = r_reg.irq;
    assign master_active_out      = master;
    assign busy_out = (r_reg.state == ST_SHIFT) || (r_reg.bit_cnt != 4'h0);

    assign sck_out     = polarity_in ^ r_reg.sck_lvl;
    assign sck_oe_out  = master && sck_dir_in;
    assign mosi_out    = r_reg.out_bit;
    assign mosi_oe_out = master && mosi_dir_in;
    assign miso_out    = r_reg.out_bit;
    assign miso_oe_out = port_on && !master && !ss_in && miso_dir_in;
    assign ss_out      = ss_level_in;
    assign ss_oe_out   = master && ss_dir_in;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_sync);

    start_on_write_a: assert property (
        master && r_reg.state == ST_IDLE && wr_take
        |=> r_reg.state == ST_SHIFT && r_reg.edge_cnt == 5'h00)
        else $error("master write did not start a byte");
    stop_after_byte_a: assert property (
        master && tick && r_reg.edge_cnt == EDGES_PER_BYTE - 5'h01
        |=> r_reg.state == ST_IDLE && r_reg.done_flag && r_reg.push)
        else $error("master did not stop after sixteen edges");
    irq_flag_a: assert property (
        r_reg.done_flag && $past(irq_enable_in) |-> irq_out)
        else $error("flag with enable gave no request");
    no_auto_select_a: assert property (
        ss_out == ss_level_in && (ss_oe_out == (master && ss_dir_in)))
        else $error("select driven by hardware");
    miso_released_a: assert property (
        ss_in && !master |-> !miso_oe_out ##1 (r_reg.bit_cnt == 4'h0))
        else $error("deselected slave is active");
    slave_byte_done_a: assert property (
        port_on && !master && !ss_in && slave_edge && sample && !wr_take &&
        r_reg.bit_cnt == BITS_PER_BYTE - 4'h1
        |=> r_reg.done_flag && r_reg.push && r_reg.bit_cnt == 4'h0)
        else $error("slave byte did not set flag");
    master_pins_a: assert property (
        master |-> !miso_oe_out && (sck_oe_out == sck_dir_in))
        else $error("master pin direction wrong");
    fault_demote_a: assert property (
        fault_ev |=> !master_active_out && r_reg.done_flag &&
        r_reg.state == ST_IDLE)
        else $error("select fault not handled");
    rate_bound_a: assert property (
        r_reg.state == ST_SHIFT |->
        r_reg.div_cnt < half_period(rate_in, double_speed_in))
        else $error("divider ran past half period");
    sck_idle_a: assert property (
        r_reg.state == ST_IDLE && master ##1 r_reg.state == ST_IDLE
        |-> sck_out == polarity_in)
        else $error("clock not at idle level");
    flag_set_wins_a: assert property (
        done && flag_clear_in |=> r_reg.done_flag)
        else $error("clear beat the completion");

    master_byte_c: cover property (
        master && tick && r_reg.edge_cnt == EDGES_PER_BYTE - 5'h01);
    slave_byte_c: cover property (!master && done && !fault_ev);
    fault_c: cover property (fault_ev);
    lsb_first_c: cover property (bit_order_in && done && phase_in);

endmodule : smsp_core

// ===== verif/smsp_peer.sv
// Far-side serial device: a plain slave that answers on miso_out.
// Assumes sck_in moves only while ss_n_in is low, as a real master does.
`timescale 1ns/1ns
module smsp_peer (
    input  wire logic       sck_in,
    input  wire logic       ss_n_in,
    input  wire logic       mosi_in,
    input  wire logic       lsb_in,
    input  wire logic       phase_in,
    input  wire logic [7:0] tx_in,
    output logic            miso_out,
    output logic [7:0]      rx_out
);
    logic [7:0] sh;
    logic       bo;
    int         n;
    assign bo = lsb_in ? sh[0] : sh[7];
    // Released line shows the inverse, never a stale copy
    assign miso_out = ss_n_in ? ~bo : bo;
    // ------------------------------------------------------------------
    // Frame start and edge handling
    // ------------------------------------------------------------------
    always @(negedge ss_n_in) begin
        n = 0;
        sh = tx_in;
    end
    // Even edges lead; phase picks which of the pair samples
    always @(sck_in) begin
        if (!ss_n_in) begin
            if (n[0] == phase_in)
                rx_out = lsb_in ? {mosi_in, rx_out[7:1]}
                                : {rx_out[6:0], mosi_in};
            else if (n != 0)
                sh = lsb_in ? (sh >> 1) : (sh << 1);
            n = n + 1;
        end
    end
endmodule : smsp_peer

// ===== verif/tb_spi_master_slave_port.sv
// Bench for the serial port: master transfers against the peer model,
// then slave frames driven from here. Pins resolve from the oe pairs.
`timescale 1ns/1ns
module tb_spi_master_slave_port;
    import smsp_pkg::*;
    logic clock_in = 0, rstn_in = 0, power_gate_in = 0, enable_in = 1;
    logic irq_enable_in = 1, bit_order_in = 0, master_select_in = 1;
    logic polarity_in = 0, phase_in = 0, double_speed_in = 0;
    logic mosi_dir_in = 1, miso_dir_in = 1, sck_dir_in = 1, ss_dir_in = 1;
    logic ss_level_in = 1, flag_clear_in = 0, wr_valid_in = 0;
    logic rd_ready_in = 0, b_sck = 0, b_mosi = 0, b_ss = 1;
    logic [1:0] rate_in = 2'h0;
    logic [7:0] wr_data_in = 8'h00, p_tx = 8'h00, p_rx, rd_data_out, d, s;
    logic wr_ready_out, rd_valid_out, transfer_done_flag_out, irq_out;
    logic master_active_out, busy_out, mosi_out, mosi_oe_out, miso_out;
    logic miso_oe_out, sck_out, sck_oe_out, ss_out, ss_oe_out, p_miso;
    int   bad_count = 0, check_count = 0, i, hv, cyc;
    wire  mosi_in = mosi_oe_out ? mosi_out : b_mosi;
    wire  miso_in = miso_oe_out ? miso_out : p_miso;
    wire  sck_in = sck_oe_out ? sck_out : b_sck;
    wire  ss_in = ss_oe_out ? ss_out : b_ss;
    smsp_core i_smsp_core (.*);
    smsp_peer i_smsp_peer (.sck_in(sck_in), .ss_n_in(ss_in),
        .mosi_in(mosi_in), .lsb_in(bit_order_in), .phase_in(phase_in),
        .tx_in(p_tx), .miso_out(p_miso), .rx_out(p_rx));
    always #10 clock_in = ~clock_in;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task check(input string n, input logic [7:0] seen, input logic [7:0] e);
        check_count++;
        if (seen !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, seen);
            bad_count++;
        end
    endtask : check
    task give_verdict;
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task wr(input logic [7:0] v);
        int k;
        wr_valid_in = 1;
        wr_data_in = v;
        k = 0;
        while (wr_ready_out !== 1'b1 && k < 100) begin
            @(negedge clock_in);
            k++;
        end
        check("wr_ready", wr_ready_out, 1);
        @(posedge clock_in);
        @(negedge clock_in);
        wr_valid_in = 0;
    endtask : wr
    task rd(output logic [7:0] v);
        check("rd_valid", rd_valid_out, 1);
        v = rd_data_out;
        rd_ready_in = 1;
        @(negedge clock_in);
        rd_ready_in = 0;
        @(negedge clock_in);
    endtask : rd
    // Phases of four clocks keep well clear of the sampling limit
    task sframe(input logic [7:0] m, output logic [7:0] r);
        int k;
        b_sck = polarity_in;
        @(negedge clock_in);
        b_ss = 0;
        repeat (4) @(negedge clock_in);
        check("miso_oe", miso_oe_out, 1);
        for (k = 7; k >= 0; k--) begin
            if (phase_in) b_sck = ~b_sck;
            b_mosi = m[k];
            repeat (4) @(negedge clock_in);
            r[k] = miso_in;
            b_sck = ~b_sck;
            repeat (4) @(negedge clock_in);
            if (!phase_in) b_sck = ~b_sck;
        end
        repeat (4) @(negedge clock_in);
        b_ss = 1;
        repeat (4) @(negedge clock_in);
    endtask : sframe
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock_in);
        bad_count++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        rstn_in = 1;
        repeat (3) @(negedge clock_in);
        // Every rate, mode, order; one pass with the interrupt masked
        for (i = 0; i < 8; i++) begin
            hv = (i % 4 == 0) ? 2 : (i % 4 == 1) ? 8 : (i % 4 == 2) ? 32 : 64;
            if (i[2]) hv = hv / 2;
            rate_in = i[1:0];
            double_speed_in = i[2];
            polarity_in = i[0];
            phase_in = i[1];
            bit_order_in = i[2];
            irq_enable_in = (i != 5);
            p_tx = 8'h3c ^ i[7:0];
            @(negedge clock_in);
            ss_level_in = 0;
            wr(8'ha5 + i[7:0]);
            cyc = 0;
            while (transfer_done_flag_out !== 1'b1 && cyc < 3000) begin
                @(negedge clock_in);
                cyc++;
                if (cyc == 2) check("wr_ready", wr_ready_out, 0);
                if (cyc == 2) check("busy", busy_out, 1);
            end
            check("cycles", cyc >= 16*hv && cyc <= 16*hv+3, 1);
            @(negedge clock_in);
            check("irq", irq_out, i != 5);
            check("busy off", busy_out, 0);
            check("sck idle", sck_out, polarity_in);
            check("ss", ss_out, 0);
            check("miso_oe", miso_oe_out, 0);
            check("peer rx", p_rx, 8'ha5 + i[7:0]);
            rd(d);
            check("rx byte", d, p_tx);
            ss_level_in = 1;
            flag_clear_in = 1;
            @(negedge clock_in);
            flag_clear_in = 0;
            repeat (2) @(negedge clock_in);
            check("irq off", irq_out, 0);
        end
        ss_dir_in = 0;
        b_ss = 0;
        repeat (4) @(negedge clock_in);
        check("master", master_active_out, 0);
        check("fault flag", transfer_done_flag_out, 1);
        check("sck_oe", sck_oe_out, 0);
        b_ss = 1;
        master_select_in = 0;
        polarity_in = 0;
        phase_in = 0;
        bit_order_in = 0;
        flag_clear_in = 1;
        @(negedge clock_in);
        flag_clear_in = 0;
        check("mosi_oe", mosi_oe_out, 0);
        check("miso idle", miso_oe_out, 0);
        wr(8'h5a);
        repeat (4) begin
            repeat (4) @(negedge clock_in);
            b_sck = ~b_sck;
        end
        sframe(8'h96, s);
        check("slave tx", s, 8'h5a);
        check("slave flag", transfer_done_flag_out, 1);
        sframe(8'h11, s);
        sframe(8'h22, s);
        rd(d);
        check("overrun 1", d, 8'h11);
        rd(d);
        check("overrun 2", d, 8'h22);
        check("empty", rd_valid_out, 0);
        // Slave in the other clock mode, least significant bit first
        polarity_in = 1;
        phase_in = 1;
        bit_order_in = 1;
        wr(8'h1e);
        sframe(8'h96, s);
        check("lsb slave tx", s, 8'h78);
        rd(d);
        check("lsb slave rx", d, 8'h69);
        power_gate_in = 1;
        @(negedge clock_in);
        check("gated ready", wr_ready_out, 0);
        check("gated miso", miso_oe_out, 0);
        give_verdict;
    end
endmodule : tb_spi_master_slave_port
